// ===== design/pmc_pkg.sv
// Purpose: constants shared by the pwm main counter block
// Assumes: 32-bit apb, each register one aligned word at four times its index
// Notes: register fields sit in the low 16 bits, upper bits read as zero
package pmc_pkg;
   // ****************************************************************
   // register indices, byte address is four times the index
   // ****************************************************************
   localparam logic [7:0] idx_port_input_select_high = 8'h06;
   localparam logic [7:0] idx_main_counter = 8'h10;
   localparam logic [7:0] idx_period_register = 8'h12;
   localparam logic [7:0] idx_timer_control_four = 8'h26;
   localparam logic [7:0] idx_timer_control_zero = 8'h2c;
   localparam logic [7:0] idx_timer_control_two = 8'h2e;
   localparam logic [7:0] idx_irq_status = 8'h60;
   localparam logic [7:0] idx_irq_mask = 8'h62;
   localparam int addr_width = 12;

   // ****************************************************************
   // field positions
   // ****************************************************************
   // timer_control_zero
   localparam int f_clk_sel_lo = 0;
   localparam int f_extra_pre = 3;
   localparam int f_dir = 4;
   localparam int f_run = 5;
   localparam int f_ste = 6;
   localparam int f_center = 7;
   // timer_control_two
   localparam int f_single_shot = 0;
   localparam int f_start_sel_lo = 8;
   // timer_control_four, write only
   localparam int f_run_clear = 0;
   localparam int f_run_set = 1;
   localparam int f_counter_reset = 2;
   localparam int f_count_trigger = 5;
   localparam int f_shadow_set = 6;
   localparam int f_shadow_clear = 7;
   // port_input_select_high
   localparam int f_in_sel_lo = 0;
   // interrupt status and mask bits
   localparam int ev_period = 0;
   localparam int ev_one = 1;
   localparam int ev_shadow = 2;
   localparam int ev_single_shot = 3;
   localparam int ev_count = 4;

   // ****************************************************************
   // encodings, reset values, timing
   // ****************************************************************
   localparam logic [1:0] in_prescaled = 2'h0;
   localparam logic [1:0] in_software = 2'h1;
   localparam logic [1:0] in_rising = 2'h2;
   localparam logic [1:0] in_falling = 2'h3;
   localparam logic [3:0] extra_prescale_shift = 4'h8;
   localparam logic [15:0] reset_value = 16'h0000;
   localparam int clock_period_ns = 50;

   typedef struct packed {
      logic [15:0] counter;
      logic [15:0] period_active;
      logic [15:0] period_shadow;
      logic [14:0] presc;
      logic dir;
      logic run;
      logic ste;
      logic center;
      logic single_shot;
      logic extra_pre;
      logic [2:0] clk_sel;
      logic [1:0] start_sel;
      logic [1:0] in_sel;
      logic sync1;
      logic sync2;
      logic sync3;
      logic [ev_count-1:0] irq_status;
      logic [ev_count-1:0] irq_mask;
      logic [31:0] prdata;
   } pmc_state_type;
endpackage

// ===== design/pmc_main_counter.sv
// Purpose: sixteen-bit up/down time base of a pwm unit with apb registers
// Assumes: single clock pclk, inputs synchronous except external_timer_input
// Notes: no dead-time counters here, so counter writes apply whenever stopped
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ns

// How it works
// - divider two power select, optional extra 256
// - prescaler held cleared while not running
// - input select picks prescaler, software, edges
// - edge mode counts up, wraps after period
// - center mode turns down after period match
// - center mode turns up after downward one
// - direction flag steers increment or decrement in center mode
// - period match when counter equals period
// - one match drives decisions, zero match is only an output
// - period reads active, writes load shadow
// - shadow transfer only while enable set
// - shadow enable changed through set/clear bits
// - run set/cleared by software, edge, hardware
// - counter reset clears counter only
// - counter writes ignored while running
// - edge single shot stops at wrap
// - center single shot stops at zero
module pmc_main_counter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pmc_pkg::addr_width-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_timer_input,
   output logic irq,
   output logic [15:0] main_counter,
   output logic count_direction_flag,
   output logic run_flag,
   output logic period_match,
   output logic zero_match,
   output logic one_match,
   output logic shadow_transfer_signal
);
   pmc_pkg::pmc_state_type st;
   pmc_pkg::pmc_state_type next_st;

   logic [7:0] idx;
   logic mapped;
   logic setup;
   logic wr;
   logic [3:0] div_exp;
   logic [14:0] div_limit;
   logic tick;
   logic rise;
   logic fall;
   logic sw_trigger;
   logic step;
   logic pm;
   logic zm;
   logic om;
   logic ctr_reset_wr;
   logic ss_stop;
   logic [31:0] rdata;
   logic [pmc_pkg::ev_count-1:0] events;

   // ****************************************************************
   // apb decode
   // ****************************************************************
   // word aligned, inside the decoded window, at a known index
   assign idx = paddr[9:2];
   always_comb begin
      unique case (idx)
         pmc_pkg::idx_port_input_select_high,
         pmc_pkg::idx_main_counter,
         pmc_pkg::idx_period_register,
         pmc_pkg::idx_timer_control_four,
         pmc_pkg::idx_timer_control_zero,
         pmc_pkg::idx_timer_control_two,
         pmc_pkg::idx_irq_status,
         pmc_pkg::idx_irq_mask: mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
         default: mapped = 1'b0;
      endcase
   end
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ****************************************************************
   // counter clock sources
   // ****************************************************************
   // divisor exponent and terminal count
   assign div_exp = {1'b0, st.clk_sel} + (st.extra_pre ? pmc_pkg::extra_prescale_shift : 4'h0);
   assign div_limit = 15'((16'h0001 << div_exp) - 16'h0001);
   assign tick = (st.presc == div_limit);
   // edges seen only on the second and third stage
   assign rise = st.sync2 && !st.sync3;
   assign fall = !st.sync2 && st.sync3;
   assign sw_trigger = wr && (idx == pmc_pkg::idx_timer_control_four)
      && pwdata[pmc_pkg::f_count_trigger];
   always_comb begin
      unique case (st.in_sel)
         pmc_pkg::in_prescaled: step = st.run && tick;
         pmc_pkg::in_software: step = st.run && sw_trigger;
         pmc_pkg::in_rising: step = st.run && rise;
         pmc_pkg::in_falling: step = st.run && fall;
      endcase
   end

   // ****************************************************************
   // match signals and shadow transfer
   // ****************************************************************
   // period comparator against the active period
   assign pm = (st.counter == st.period_active);
   assign zm = (st.counter == 16'h0000);
   assign om = (st.counter == 16'h0001);
   assign ctr_reset_wr = wr && (idx == pmc_pkg::idx_timer_control_four)
      && pwdata[pmc_pkg::f_counter_reset];
   // edge mode single shot ends at the wrap step
   // center mode ends on the step from one down to zero
   assign ss_stop = step && st.single_shot
      && (st.center ? (om && st.dir) : pm);
   // gated by enable, turning points while running, at once when stopped
   always_comb begin
      if (!st.ste) begin
         shadow_transfer_signal = 1'b0;
      end else if (!st.run) begin
         shadow_transfer_signal = 1'b1;
      end else if (st.center) begin
         shadow_transfer_signal = step && ((pm && !st.dir) || (om && st.dir));
      end else begin
         shadow_transfer_signal = step && pm;
      end
   end

   // interrupt events
   always_comb begin
      events = '0;
      events[pmc_pkg::ev_period] = step && pm;
      events[pmc_pkg::ev_one] = step && om;
      events[pmc_pkg::ev_shadow] = shadow_transfer_signal;
      events[pmc_pkg::ev_single_shot] = ss_stop;
   end

   // ****************************************************************
   // read mux
   // ****************************************************************
   always_comb begin
      rdata = 32'h00000000;
      unique case (idx)
         pmc_pkg::idx_port_input_select_high: begin
            rdata[pmc_pkg::f_in_sel_lo +: 2] = st.in_sel;
         end
         pmc_pkg::idx_main_counter: begin
            rdata[15:0] = st.counter;
         end
         pmc_pkg::idx_period_register: begin
            rdata[15:0] = st.period_active;
         end
         pmc_pkg::idx_timer_control_zero: begin
            rdata[pmc_pkg::f_clk_sel_lo +: 3] = st.clk_sel;
            rdata[pmc_pkg::f_extra_pre] = st.extra_pre;
            rdata[pmc_pkg::f_dir] = st.dir;
            rdata[pmc_pkg::f_run] = st.run;
            rdata[pmc_pkg::f_ste] = st.ste;
            rdata[pmc_pkg::f_center] = st.center;
         end
         pmc_pkg::idx_timer_control_two: begin
            rdata[pmc_pkg::f_single_shot] = st.single_shot;
            rdata[pmc_pkg::f_start_sel_lo +: 2] = st.start_sel;
         end
         pmc_pkg::idx_irq_status: begin
            rdata[pmc_pkg::ev_count-1:0] = st.irq_status;
         end
         pmc_pkg::idx_irq_mask: begin
            rdata[pmc_pkg::ev_count-1:0] = st.irq_mask;
         end
         default: rdata = 32'h00000000;
      endcase
      if (!mapped) begin
         rdata = 32'h00000000;
      end
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_st = st;
      next_st.sync1 = external_timer_input;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      // read data is captured in the setup cycle
      if (setup && !pwrite) begin
         next_st.prdata = rdata;
      end
      if (!st.run || tick) begin
         next_st.presc = 15'h0000;
      end else begin
         next_st.presc = 15'(st.presc + 15'h0001);
      end
      // configuration writes
      if (wr) begin
         unique case (idx)
            pmc_pkg::idx_port_input_select_high: begin
               next_st.in_sel = pwdata[pmc_pkg::f_in_sel_lo +: 2];
            end
            // writes go to the shadow only
            pmc_pkg::idx_period_register: begin
               next_st.period_shadow = pwdata[15:0];
            end
            pmc_pkg::idx_timer_control_zero: begin
               next_st.clk_sel = pwdata[pmc_pkg::f_clk_sel_lo +: 3];
               next_st.extra_pre = pwdata[pmc_pkg::f_extra_pre];
               next_st.center = pwdata[pmc_pkg::f_center];
            end
            pmc_pkg::idx_timer_control_two: begin
               next_st.single_shot = pwdata[pmc_pkg::f_single_shot];
               next_st.start_sel = pwdata[pmc_pkg::f_start_sel_lo +: 2];
            end
            pmc_pkg::idx_irq_mask: begin
               next_st.irq_mask = pwdata[pmc_pkg::ev_count-1:0];
            end
            default: begin
               next_st.in_sel = st.in_sel;
            end
         endcase
      end
      if (wr && (idx == pmc_pkg::idx_main_counter) && !st.run) begin
         next_st.counter = pwdata[15:0];
      end
      // count by the current direction flag in center mode, up in edge mode
      if (step) begin
         if (!st.center) begin
            // edge mode up only, wrap after period
            next_st.dir = 1'b0;
            next_st.counter = pm ? 16'h0000 : 16'(st.counter + 16'h0001);
         end else begin
            next_st.counter = st.dir ? 16'(st.counter - 16'h0001)
               : 16'(st.counter + 16'h0001);
            if (!st.dir && pm) begin
               next_st.dir = 1'b1;
            end
            // turn up after downward one match
            if (st.dir && om) begin
               next_st.dir = 1'b0;
            end
         end
      end
      // counter reset leaves run and direction alone
      if (ctr_reset_wr) begin
         next_st.counter = 16'h0000;
      end
      // shadow period moves on transfer, enable is spent
      if (shadow_transfer_signal) begin
         next_st.period_active = st.period_shadow;
         next_st.ste = 1'b0;
      end
      // software changes enable only via set and clear bits, set wins
      if (wr && (idx == pmc_pkg::idx_timer_control_four)) begin
         if (pwdata[pmc_pkg::f_shadow_clear]) begin
            next_st.ste = 1'b0;
         end
         if (pwdata[pmc_pkg::f_shadow_set]) begin
            next_st.ste = 1'b1;
         end
      end
      // clears first, then sets so a set wins
      if (ss_stop) begin
         next_st.run = 1'b0;
      end
      if (wr && (idx == pmc_pkg::idx_timer_control_four)) begin
         if (pwdata[pmc_pkg::f_run_clear]) begin
            next_st.run = 1'b0;
         end
         if (pwdata[pmc_pkg::f_run_set]) begin
            next_st.run = 1'b1;
         end
      end
      if ((st.start_sel[0] && rise) || (st.start_sel[1] && fall)) begin
         next_st.run = 1'b1;
      end
      // sticky status, write one clears, new event wins
      if (wr && (idx == pmc_pkg::idx_irq_status)) begin
         next_st.irq_status = st.irq_status & ~pwdata[pmc_pkg::ev_count-1:0];
      end
      next_st.irq_status = next_st.irq_status | events;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // outputs
   assign prdata = st.prdata;
   assign irq = |(st.irq_status & st.irq_mask);
   assign main_counter = st.counter;
   assign count_direction_flag = st.dir;
   assign run_flag = st.run;
   assign period_match = pm;
   assign zero_match = zm;
   assign one_match = om;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // stopped counter keeps the prescaler at zero
   a_prescale_held: assert property (!st.run |=> st.presc == 15'h0000)
      else $error("prescaler not cleared while stopped");

   // prescaled mode steps exactly at the divisor
   a_prescale_tick: assert property (st.run && st.in_sel == pmc_pkg::in_prescaled
      && st.presc == div_limit |-> step)
      else $error("prescaler terminal count gave no step");

   // edge mode wraps to zero after period
   a_edge_wrap: assert property (step && !st.center && pm && !ctr_reset_wr
      |=> st.counter == 16'h0000 && !st.dir)
      else $error("edge mode did not wrap after period");

   // center mode turns down after period match
   a_center_turn: assert property (step && st.center && !st.dir && pm
      |=> st.dir && st.counter == 16'($past(st.counter) + 16'h0001))
      else $error("center mode failed to overshoot and turn down");

   // center mode turns up after the downward one match
   a_center_up: assert property (step && st.center && st.dir && om && !ctr_reset_wr
      |=> !st.dir && st.counter == 16'h0000)
      else $error("center mode failed to turn up at one");

   // a down step decrements by one
   a_count_down: assert property (step && st.dir && !ctr_reset_wr
      |=> st.counter == 16'($past(st.counter) - 16'h0001))
      else $error("down step did not decrement");

   // no transfer without enable, and enable is spent by it
   a_shadow_gate: assert property (shadow_transfer_signal && !wr
      |-> st.ste ##1 !st.ste && st.period_active == $past(st.period_shadow))
      else $error("shadow transfer misbehaved");

   // counter reset clears counter and leaves run alone
   a_counter_reset: assert property (ctr_reset_wr && !ss_stop
      && !pwdata[pmc_pkg::f_run_clear] && !pwdata[pmc_pkg::f_run_set]
      |=> st.counter == 16'h0000 && st.run == $past(st.run))
      else $error("counter reset disturbed other state");

   // counter writes while running are not taken
   a_write_ignored: assert property (wr && idx == pmc_pkg::idx_main_counter
      && st.run && !step |=> st.counter == $past(st.counter))
      else $error("counter write taken while running");

   // edge single shot stops at the wrap
   a_shot_edge: assert property (step && st.single_shot && !st.center && pm
      && !(st.start_sel[0] && rise) && !(st.start_sel[1] && fall)
      && !(wr && idx == pmc_pkg::idx_timer_control_four) |=> !st.run)
      else $error("edge single shot did not stop");

   // center single shot stops on the step from one to zero
   a_shot_center: assert property (step && st.single_shot && st.center && st.dir && om
      && !(st.start_sel[0] && rise) && !(st.start_sel[1] && fall)
      && !(wr && idx == pmc_pkg::idx_timer_control_four) |=> !st.run)
      else $error("center single shot did not stop");
endmodule

// ===== verification/pmc_main_counter_tb.sv
// Purpose: self-checking bench for the pwm main counter block over apb
// Assumes: zero wait state apb, pclk at 20 MHz, counter steps from pclk
// Notes: outputs are sampled at rising edges, before that edge's updates land
`timescale 1ns/1ns
module pmc_main_counter_tb;
   // ****************************************************************
   // signals and register shorthands
   // ****************************************************************
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [pmc_pkg::addr_width-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0;
   logic ext = 1'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, dir, run, pm, zm, om, st;
   logic [15:0] cnt;
   logic [31:0] rd;
   logic err_seen;
   int err_count = 0;
   int tests_run = 0;
   int cyc;
   int sel[4] = '{0, 3, 7, 0};
   int pre[4] = '{0, 0, 0, 1};
   localparam logic [7:0] c0 = pmc_pkg::idx_timer_control_zero;
   localparam logic [7:0] c2 = pmc_pkg::idx_timer_control_two;
   localparam logic [7:0] c4 = pmc_pkg::idx_timer_control_four;
   localparam logic [7:0] pr = pmc_pkg::idx_period_register;
   localparam logic [7:0] mc = pmc_pkg::idx_main_counter;
   localparam logic [7:0] ps = pmc_pkg::idx_port_input_select_high;
   localparam logic [7:0] is = pmc_pkg::idx_irq_status;
   localparam logic [7:0] im = pmc_pkg::idx_irq_mask;

   pmc_main_counter i_dut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .external_timer_input(ext),
      .irq(irq),
      .main_counter(cnt),
      .count_direction_flag(dir),
      .run_flag(run),
      .period_match(pm),
      .zero_match(zm),
      .one_match(om),
      .shadow_transfer_signal(st)
   );

   // clock generator
   always #(pmc_pkg::clock_period_ns / 2) pclk = ~pclk;

   // ****************************************************************
   // tasks
   // ****************************************************************
   function automatic logic [31:0] bit_of(input int k);
      return 32'h1 << k;
   endfunction

   // compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer, released at the pready edge, then one idle edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= (pmc_pkg::addr_width)'({idx, 2'h0});
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      // a slave that never answers counts as a mismatch
      if (n >= 50) begin
         err_count++;
      end
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   // read a register and compare the masked value
   task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] m,
                       input logic [31:0] exp);
      apb(1'h0, idx, 32'h0);
      check(name, rd & m, exp);
   endtask

   // wait for the counter to change, counting edges
   task automatic next_step(output int c);
      logic [15:0] last;
      last = cnt;
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (cnt === last && c < 2000);
   endtask

   // follow steps one clock apart; bit 16 of each entry is the direction
   task automatic steps(input string name, input logic [15:0] per, input logic [16:0] v[$]);
      foreach (v[i]) begin
         next_step(cyc);
         check(name, {cyc == 1, dir, cnt}, {1'h1, v[i]});
         check(name, {pm, zm, om}, {v[i][15:0] == per, v[i][15:0] == 0, v[i][15:0] == 1});
      end
   endtask

   // move the external pin and give the synchroniser time
   task automatic pin(input logic v);
      ext <= v;
      repeat (6) @(posedge pclk);
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ****************************************************************
   // watchdog
   // ****************************************************************
   initial begin
      #(pmc_pkg::clock_period_ns * 30000);
      err_count++;
      end_of_test;
   end

   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      rchk("control zero reset", c0, 32'hffff_ffff, 32'h0);
      rchk("counter reset", mc, 32'hffff_ffff, 32'h0);
      apb(1'h0, 8'h01, 32'h0);
      check("unmapped error", err_seen, 1'h1);
      check("unmapped data", rd, 32'h0);
      check("ready high", pready, 1'h1);
      $display("test reset done");
      apb(1'h1, pr, 32'h3);
      check("transfer idle", st, 1'h0);
      rchk("period before transfer", pr, 32'hffff, 32'h0);
      apb(1'h1, c0, bit_of(pmc_pkg::f_ste));
      rchk("enable direct write", c0, bit_of(pmc_pkg::f_ste), 32'h0);
      apb(1'h1, c4, bit_of(pmc_pkg::f_shadow_set));
      check("transfer pulse", st, 1'h1);
      rchk("period after transfer", pr, 32'hffff, 32'h3);
      apb(1'h1, pr, 32'h64);
      rchk("period kept", pr, 32'hffff, 32'h3);
      $display("test shadow done");
      apb(1'h1, c4, bit_of(pmc_pkg::f_run_set));
      steps("edge count", 16'h3, '{17'h1, 17'h2, 17'h3, 17'h0, 17'h1});
      apb(1'h1, c4, bit_of(pmc_pkg::f_run_clear));
      check("run cleared", run, 1'h0);
      rchk("period event", is, 32'h1, 32'h1);
      apb(1'h1, im, 32'h1);
      check("irq unmasked", irq, 1'h1);
      apb(1'h1, im, 32'h0);
      check("irq masked", irq, 1'h0);
      apb(1'h1, im, 32'h1);
      apb(1'h1, is, 32'h1f);
      check("irq cleared", irq, 1'h0);
      rchk("status cleared", is, 32'hffff, 32'h0);
      $display("test edge done");
      // reset keeps run, running writes ignored
      apb(1'h1, c4, bit_of(pmc_pkg::f_shadow_set));
      apb(1'h1, c4, bit_of(pmc_pkg::f_run_set));
      apb(1'h1, c4, bit_of(pmc_pkg::f_counter_reset));
      check("reset keeps run", {run, cnt}, {1'h1, 16'h0});
      apb(1'h1, mc, 32'h32);
      check("running write", cnt, 16'h3);
      apb(1'h1, c4, bit_of(pmc_pkg::f_run_clear));
      apb(1'h1, mc, 32'h7);
      rchk("stopped write", mc, 32'hffff, 32'h7);
      $display("test counter write done");
      foreach (sel[i]) begin
         apb(1'h1, c4, bit_of(pmc_pkg::f_run_clear));
         apb(1'h1, c0, 32'(sel[i]) | (32'(pre[i]) << pmc_pkg::f_extra_pre));
         apb(1'h1, c4, bit_of(pmc_pkg::f_run_set));
         next_step(cyc);
         check("first step", cyc, 1 << (sel[i] + 8 * pre[i]));
         next_step(cyc);
         check("step spacing", cyc, 1 << (sel[i] + 8 * pre[i]));
      end
      // enable set and clear while running
      apb(1'h1, c4, bit_of(pmc_pkg::f_shadow_set));
      check("no transfer mid period", st, 1'h0);
      rchk("enable set", c0, bit_of(pmc_pkg::f_ste), bit_of(pmc_pkg::f_ste));
      apb(1'h1, c4, bit_of(pmc_pkg::f_shadow_clear));
      rchk("enable clear", c0, bit_of(pmc_pkg::f_ste), 32'h0);
      $display("test prescaler done");
      apb(1'h1, c4, bit_of(pmc_pkg::f_run_clear) | bit_of(pmc_pkg::f_counter_reset));
      apb(1'h1, pr, 32'h3);
      apb(1'h1, c4, bit_of(pmc_pkg::f_shadow_set));
      apb(1'h1, c0, bit_of(pmc_pkg::f_center));
      apb(1'h1, c2, bit_of(pmc_pkg::f_single_shot));
      apb(1'h1, c4, bit_of(pmc_pkg::f_run_set));
      steps("center count", 16'h3, '{17'h1, 17'h2, 17'h3, 17'h10004, 17'h10003,
            17'h10002, 17'h10001, 17'h0});
      repeat (3) @(posedge pclk);
      check("center stop", {run, dir, cnt}, 18'h0);
      rchk("stop event", is, bit_of(pmc_pkg::ev_single_shot), bit_of(pmc_pkg::ev_single_shot));
      apb(1'h1, c0, 32'h0);
      apb(1'h1, c4, bit_of(pmc_pkg::f_run_set));
      steps("edge shot", 16'h3, '{17'h1, 17'h2, 17'h3, 17'h0});
      repeat (3) @(posedge pclk);
      check("edge stop", {run, cnt}, 17'h0);
      $display("test single shot done");
      apb(1'h1, c2, 32'h0);
      apb(1'h1, ps, 32'(pmc_pkg::in_software));
      apb(1'h1, c4, bit_of(pmc_pkg::f_run_set));
      repeat (4) @(posedge pclk);
      check("no trigger", cnt, 16'h0);
      apb(1'h1, c4, bit_of(pmc_pkg::f_count_trigger));
      check("software step", cnt, 16'h1);
      apb(1'h1, ps, 32'(pmc_pkg::in_rising));
      pin(1'h1);
      check("rising step", cnt, 16'h2);
      pin(1'h0);
      check("rising ignores fall", cnt, 16'h2);
      apb(1'h1, ps, 32'(pmc_pkg::in_falling));
      pin(1'h1);
      check("falling ignores rise", cnt, 16'h2);
      pin(1'h0);
      check("falling step", cnt, 16'h3);
      apb(1'h1, c4, bit_of(pmc_pkg::f_run_clear));
      apb(1'h1, c2, bit_of(pmc_pkg::f_start_sel_lo));
      pin(1'h1);
      check("rising start", run, 1'h1);
      apb(1'h1, c4, bit_of(pmc_pkg::f_run_clear));
      apb(1'h1, c2, bit_of(pmc_pkg::f_start_sel_lo + 1));
      check("stopped before fall", run, 1'h0);
      pin(1'h0);
      check("falling start", run, 1'h1);
      $display("test inputs done");
      end_of_test;
   end
endmodule
